//--- afq_regs.vh
// Constants for the 16x5 strobed FIFO with flags.
// Assumes inclusion by the FIFO core and its edge detector only.
`ifndef AFQ_REGS_VH
`define AFQ_REGS_VH

`define AFQ_DEPTH        16
`define AFQ_WIDTH        5
`define AFQ_PTR_W        4
`define AFQ_CNT_W        5
`define AFQ_NEAR_FULL    5'h0E
`define AFQ_NEAR_EMPTY   5'h02
`define AFQ_CNT_RST      5'h00
`define AFQ_PTR_RST      4'h0

`endif

//--- afq_edge.v
// Rising-edge detector for a strobe from outside the clock domain.
// Assumes ref_clk is much faster than the strobe (180 ns period or more in the bench).
`timescale 1ns/100ps
`include "afq_regs.vh"

module afq_edge (
    // Clock, reset, enable
    input  wire ref_clk,
    input  wire resetn,
    input  wire clk_en,
    // Strobe in, edge pulse out
    input  wire strobe_in,
    output wire rise_pulse
);

    reg sync1_q;
    reg sync2_q;
    reg last_q;

    // Two flops before use; first flop feeds only the second
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            last_q  <= 1'b0;
        end else if (clk_en) begin
            sync1_q <= strobe_in;
            sync2_q <= sync1_q;
            last_q  <= sync2_q;
        end
    end

    assign rise_pulse = clk_en & sync2_q & ~last_q;

endmodule // afq_edge

//--- afq_fifo.v
// 16-word by 5-bit strobed FIFO core with full, empty and near flags.
// Assumes load and unload strobes arrive as slow levels from other systems;
// both are sampled on ref_clk, so coincident edges resolve in one cycle.
//
// Design decisions made here: the strobed register port.
`timescale 1ns/100ps
`include "afq_regs.vh"

module afq_fifo #(
    parameter DEPTH = `AFQ_DEPTH,
    parameter WIDTH = `AFQ_WIDTH
) (
    // Clock, reset, enable
    input  wire             ref_clk,
    input  wire             resetn,
    input  wire             clk_en,
    // Producer side
    input  wire             load_strobe,
    input  wire [WIDTH-1:0] data_in,
    // Consumer side
    input  wire             unload_strobe,
    input  wire             out_enable,
    output wire [WIDTH-1:0] data_out,
    output wire [WIDTH-1:0] data_out_oe_n,
    output wire             data_valid,
    // Status flags, active low
    output wire             full_n,
    output wire             near_full_n,
    output wire             empty_n,
    output wire             near_empty_n,
    // Interrupt
    input  wire             irq_read,
    output wire [3:0]       irq_status,
    input  wire [3:0]       irq_mask_in,
    input  wire             irq_mask_wr,
    output wire             irq
);

    // ************************************************************
    // Strobe synchronisation and edge detection
    // ************************************************************
    wire load_rise;
    wire unload_rise;

    afq_edge u_load_edge (
        .ref_clk    (ref_clk),
        .resetn     (resetn),
        .clk_en     (clk_en),
        .strobe_in  (load_strobe),
        .rise_pulse (load_rise)
    );

    afq_edge u_unload_edge (
        .ref_clk    (ref_clk),
        .resetn     (resetn),
        .clk_en     (clk_en),
        .strobe_in  (unload_strobe),
        .rise_pulse (unload_rise)
    );

    // Data bus sampled with the strobe: two flops keep it aligned with the edge
    reg [WIDTH-1:0] din1_q;
    reg [WIDTH-1:0] din2_q;

    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            din1_q <= {WIDTH{1'b0}};
            din2_q <= {WIDTH{1'b0}};
        end else if (clk_en) begin
            din1_q <= data_in;
            din2_q <= din1_q;
        end
    end

    // ************************************************************
    // Pointers and word count
    // ************************************************************
    reg  [`AFQ_PTR_W-1:0] wr_ptr_q;
    reg  [`AFQ_PTR_W-1:0] rd_ptr_q;
    reg  [`AFQ_CNT_W-1:0] stored_word_count_q;
    reg  [`AFQ_CNT_W-1:0] stored_word_count_d;

    wire is_full  = (stored_word_count_q == DEPTH);
    wire is_empty = (stored_word_count_q == `AFQ_CNT_RST);
    wire do_load   = load_rise & ~is_full;
    wire do_unload = unload_rise & ~is_empty;

    // One counter sees both edges in the same cycle, so nothing slips
    always @* begin
        stored_word_count_d = stored_word_count_q;
        case ({do_load, do_unload})
            2'b10:   stored_word_count_d = stored_word_count_q + 5'h01;
            2'b01:   stored_word_count_d = stored_word_count_q - 5'h01;
            default: stored_word_count_d = stored_word_count_q;
        endcase
    end

    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr_q            <= `AFQ_PTR_RST;
            rd_ptr_q            <= `AFQ_PTR_RST;
            stored_word_count_q <= `AFQ_CNT_RST;
        end else if (clk_en) begin
            if (do_load)
                wr_ptr_q <= wr_ptr_q + 4'h1;
            if (do_unload)
                rd_ptr_q <= rd_ptr_q + 4'h1;
            stored_word_count_q <= stored_word_count_d;
        end
    end

    // ************************************************************
    // Storage, flip-flops per entry
    // ************************************************************
    // Contents are not cleared: reset leaves the output word undefined
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];

    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_word
            always @(posedge ref_clk) begin
                if (clk_en && do_load && (wr_ptr_q == gi))
                    mem_q[gi] <= din2_q;
            end
        end
    endgenerate

    // ************************************************************
    // Fall-through output register
    // ************************************************************
    reg [WIDTH-1:0] dout_q;

    // Head word shown as soon as stored; showing it does not pop it
    always @(posedge ref_clk) begin
        if (clk_en) begin
            // A coincident load and unload at one word makes the new word the head
            if (do_load && (is_empty || (do_unload && stored_word_count_q == 5'h01)))
                dout_q <= din2_q;
            else if (do_unload && stored_word_count_q > 5'h01)
                dout_q <= mem_q[rd_ptr_q + 4'h1];
        end
    end

    assign data_out      = dout_q;
    assign data_out_oe_n = {WIDTH{~out_enable}};
    assign data_valid    = ~is_empty;

    // ************************************************************
    // Status flags
    // ************************************************************
    // Flags registered from the next count so they track the counter
    reg full_n_q;
    reg near_full_n_q;
    reg empty_n_q;
    reg near_empty_n_q;

    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            full_n_q       <= 1'b1;
            near_full_n_q  <= 1'b1;
            empty_n_q      <= 1'b0;
            near_empty_n_q <= 1'b1;
        end else if (clk_en) begin
            full_n_q       <= (stored_word_count_d != DEPTH);
            near_full_n_q  <= (stored_word_count_d != `AFQ_NEAR_FULL);
            empty_n_q      <= (stored_word_count_d != `AFQ_CNT_RST);
            near_empty_n_q <= (stored_word_count_d != `AFQ_NEAR_EMPTY);
        end
    end

    // Flags ignore out_enable entirely
    assign full_n       = full_n_q;
    assign near_full_n  = near_full_n_q;
    assign empty_n      = empty_n_q;
    assign near_empty_n = near_empty_n_q;

    // ************************************************************
    // Interrupts
    // ************************************************************
    // Events: became full, near full, empty after unload, near empty
    reg  [3:0] irq_stat_q;
    reg  [3:0] irq_mask_q;
    wire [3:0] irq_event;

    assign irq_event[0] = do_load & ~do_unload & (stored_word_count_d == DEPTH);
    assign irq_event[1] = (stored_word_count_d == `AFQ_NEAR_FULL) & near_full_n_q;
    assign irq_event[2] = do_unload & ~do_load & (stored_word_count_d == `AFQ_CNT_RST);
    assign irq_event[3] = (stored_word_count_d == `AFQ_NEAR_EMPTY) & near_empty_n_q;

    // Set beats the clearing read so no event is lost
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            irq_stat_q <= 4'h0;
            irq_mask_q <= 4'h0;
        end else if (clk_en) begin
            irq_stat_q <= (irq_read ? 4'h0 : irq_stat_q) | irq_event;
            if (irq_mask_wr)
                irq_mask_q <= irq_mask_in;
        end
    end

    assign irq_status = irq_stat_q;
    assign irq        = |(irq_stat_q & irq_mask_q);

endmodule // afq_fifo

//--- afq_fifo_assertions.sv
// Checker for the strobed FIFO flags and output enable.
// Assumes binding to afq_fifo; sees only its ports.
`timescale 1ns/100ps
module afq_fifo_chk #(parameter WIDTH = 5) (
    // Clock and reset
    input logic             ref_clk,
    input logic             resetn,
    // Watched ports
    input logic             out_enable,
    input logic [WIDTH-1:0] data_out_oe_n,
    input logic             data_valid,
    input logic             full_n,
    input logic             near_full_n,
    input logic             empty_n,
    input logic             near_empty_n,
    input logic [3:0]       irq_status,
    input logic             irq
);
    // ****
    // Properties
    // ****
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    chk_valid_empty: assert property (data_valid == empty_n)
        else $error("valid vs empty");
    chk_oe_follow: assert property (data_out_oe_n == {WIDTH{!out_enable}})
        else $error("oe mismatch");
    chk_full_alone: assert property (!full_n |-> empty_n && near_full_n)
        else $error("full with other flag");
    chk_nfull_mid: assert property (!near_full_n |-> full_n && empty_n)
        else $error("near full with other flag");
    chk_nempty_mid: assert property (!near_empty_n |-> full_n && empty_n)
        else $error("near empty with other flag");
    chk_full_step: assert property ($fell(full_n) |-> $past(empty_n) && $past(near_full_n))
        else $error("full not from fifteen");
    chk_empty_step: assert property ($fell(empty_n) |-> $past(near_empty_n))
        else $error("empty not from one");
    chk_irq_cause: assert property (irq |-> irq_status != 4'h0)
        else $error("irq without status");
endmodule // afq_fifo_chk
bind afq_fifo afq_fifo_chk #(.WIDTH(WIDTH)) i_afq_fifo_chk (.ref_clk, .resetn, .out_enable,
    .data_out_oe_n, .data_valid, .full_n, .near_full_n, .empty_n, .near_empty_n,
    .irq_status, .irq);

//--- afq_partner.sv
// Producer and consumer model on the two strobes.
// Assumes a 20 ns ref_clk; a strobe period is at least 180 ns.
`timescale 1ns/100ps
module afq_partner (
    // Clock
    input  logic       ref_clk,
    // Strobes and data
    output logic       load_strobe,
    output logic       unload_strobe,
    output logic [4:0] data_in
);
    initial begin
        load_strobe = 1'b0;
        unload_strobe = 1'b0;
        data_in = 5'h15;
    end
    // High four clocks, low gap plus five clocks; data held through high and the first four low clocks
    task automatic strobe(input logic ld, input logic ul, input logic [4:0] w, input int gap);
        repeat (gap + 1) @(posedge ref_clk);
        data_in <= w;
        load_strobe <= ld;
        unload_strobe <= ul;
        repeat (4) @(posedge ref_clk);
        load_strobe <= 1'b0;
        unload_strobe <= 1'b0;
        repeat (4) @(posedge ref_clk);
        // Stale data never left on the bus
        data_in <= ~w;
    endtask
endmodule // afq_partner

//--- tb_top.sv
// Self-checking bench for the 16x5 strobed FIFO.
// Assumes afq_fifo, afq_partner and the checker are compiled.
`timescale 1ns/100ps
module tb_top;
    logic       ref_clk;
    logic       resetn = 1'b0;
    logic       clk_en = 1'b1;
    logic       out_enable = 1'b1;
    logic       irq_read = 1'b0;
    logic       irq_mask_wr = 1'b0;
    logic [3:0] irq_mask_in = 4'h0;
    logic       load_strobe, unload_strobe, data_valid, full_n, near_full_n;
    logic       empty_n, near_empty_n, irq, a;
    logic [4:0] data_in, data_out, data_out_oe_n;
    logic [3:0] irq_status;
    int         failures = 0;
    int         samples_checked = 0;
    afq_fifo i_afq_fifo (.ref_clk, .resetn, .clk_en, .load_strobe, .data_in, .unload_strobe,
        .out_enable, .data_out, .data_out_oe_n, .data_valid, .full_n, .near_full_n, .empty_n,
        .near_empty_n, .irq_read, .irq_status, .irq_mask_in, .irq_mask_wr, .irq);
    afq_partner i_afq_partner (.ref_clk, .load_strobe, .unload_strobe, .data_in);
    // ****
    // Checks and scenarios
    // ****
    task automatic cmp(input string nm, input logic [4:0] e, input logic [4:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic flags(input int n);
        cmp("flags", {n != 0, n != 16, n != 14, n != 0, n != 2},
            {data_valid, full_n, near_full_n, empty_n, near_empty_n});
    endtask
    task automatic mask(input logic [3:0] m);
        @(posedge ref_clk);
        irq_mask_in <= m;
        irq_mask_wr <= 1'b1;
        @(posedge ref_clk);
        irq_mask_wr <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic t_fill;
        for (int i = 0; i < 17; i++) begin
            i_afq_partner.strobe(1'b1, 1'b0, 5'(i + 3), 0);
            flags(i < 16 ? i + 1 : 16);
            cmp("head", 5'h03, data_out);
        end
    endtask
    task automatic t_irq;
        mask(4'h0);
        a = irq;
        mask(4'hF);
        cmp("irq", 5'h01, {4'h0, irq ^ a});
        @(posedge ref_clk);
        irq_read <= 1'b1;
        @(posedge ref_clk);
        irq_read <= 1'b0;
        @(posedge ref_clk);
        cmp("status", 5'h00, {1'b0, irq_status});
    endtask
    task automatic t_drain;
        for (int i = 0; i < 17; i++) begin
            if (i < 16)
                cmp("head", 5'(i + 3), data_out);
            i_afq_partner.strobe(1'b0, 1'b1, 5'h00, i % 3);
            flags(i < 16 ? 15 - i : 0);
        end
    endtask
    task automatic t_both;
        i_afq_partner.strobe(1'b1, 1'b1, 5'h0A, 0);
        flags(1);
        cmp("head", 5'h0A, data_out);
        i_afq_partner.strobe(1'b1, 1'b1, 5'h11, 1);
        flags(1);
        out_enable <= 1'b0;
        repeat (2) @(posedge ref_clk);
        cmp("oe_n", 5'h1F, data_out_oe_n);
        flags(1);
        out_enable <= 1'b1;
        repeat (2) @(posedge ref_clk);
        cmp("head", 5'h11, data_out);
        cmp("oe_n", 5'h00, data_out_oe_n);
    endtask
    task automatic print_verdict;
        $display("failures %0d samples_checked %0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        flags(0);
        resetn <= 1'b1;
        t_fill;
        t_irq;
        t_drain;
        t_both;
        print_verdict;
    end
    // Run needs about 7.2 us
    initial begin
        #400000;
        failures++;
        print_verdict;
    end
endmodule // tb_top
